// ### shared/pfrs_defines.svh
// Constants for the power-failure response sequencer: timing, offsets, fields and resets.
`ifndef PFRS_DEFINES_SVH
`define PFRS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
// Clock period in ns, length of one millisecond in ns, and the cycles in it.
`define PFRS_CLK_NS 10
`define PFRS_MS_NS 1000000
`define PFRS_CYC_PER_MS (`PFRS_MS_NS / `PFRS_CLK_NS)
// Interruption lengths in ms: the ride-through limit and the sure-detection limit.
`define PFRS_STD_IGNORE_MS 20
`define PFRS_AC_IGNORE_MS 10
`define PFRS_AC_ALWAYS_MS 25
`define PFRS_DC_IGNORE_MS 2
`define PFRS_DC_ALWAYS_MS 10
// Width of the saturating outage millisecond count.
`define PFRS_MS_W 8

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PFRS_OFS_CTRL 8'h00
`define PFRS_OFS_STATUS 8'h04
`define PFRS_OFS_IRQ_STAT 8'h08
`define PFRS_OFS_IRQ_MASK 8'h0C
`define PFRS_OFS_LOG_TIME 8'h10
`define PFRS_OFS_CLOCK 8'h14

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define PFRS_CTRL_IMM 0
`define PFRS_CTRL_DC 1
`define PFRS_CTRL_CLR 2
`define PFRS_CTRL_W 3
`define PFRS_CTRL_RST 3'h0
`define PFRS_EV_MOM 0
`define PFRS_EV_PWR 1
`define PFRS_EV_RST 2
`define PFRS_EV_RES 3
`define PFRS_EV_W 4
`define PFRS_EV_RST_VAL 4'h0

`endif

// ### shared/pfrs_pkg.sv
// Types shared by the power-failure response sequencer modules.
package pfrs_pkg;

   // Sequencer states; each step of a multi-step reaction takes one state.
   typedef enum logic [3:0] {
      ST_RUN,
      ST_SUSP,
      ST_RESUME,
      ST_IMM_OUT,
      ST_IMM_SUSP,
      ST_IMM_FAIL,
      ST_HALT,
      ST_OFF,
      ST_FAIL,
      ST_DIS,
      ST_RESTART
   } pfrs_state_e;

endpackage

// ### shared/pfrs_tmr_if.sv
// Interface between the sequencer core and its outage timer.
`timescale 1ns/1ps
`include "pfrs_defines.svh"

interface pfrs_tmr_if;
   logic loss;                          // Synchronised supply-loss level.
   logic [`PFRS_MS_W-1:0] ms_count;     // Whole ms elapsed since loss rose.
   logic ms_tick;                       // Free-running one-cycle ms pulse.

   modport timer (input loss, output ms_count, output ms_tick);
   modport user (output loss, input ms_count, input ms_tick);
endinterface

// ### hdl/pfrs_sync.sv
// Two-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps

module pfrs_sync #(
   parameter int W = 1
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   // First stage; only the second stage reads it.
   logic [W-1:0] meta;

   // Both stages clear on reset so a supply fault is not seen before it is real.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         meta <= '0;
         Q <= '0;
      end else begin
         meta <= D;
         Q <= meta;
      end
   end
endmodule // pfrs_sync

// ### hdl/pfrs_ms_timer.sv
// Outage millisecond counter and free-running millisecond tick.
`timescale 1ns/1ps
`include "pfrs_defines.svh"

module pfrs_ms_timer #(
   parameter int CYC_PER_MS = `PFRS_CYC_PER_MS
) (
   input wire logic CLK,
   input wire logic RST,
   pfrs_tmr_if.timer tmr
);
   localparam int CW = $clog2(CYC_PER_MS + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

   logic [CW-1:0] loss_sub;   // Cycles into the current outage millisecond.
   logic [CW-1:0] free_sub;   // Cycles into the current free millisecond.
   wire loss_ms_done = (loss_sub == LAST);
   wire free_ms_done = (free_sub == LAST);
   wire cnt_sat = &tmr.ms_count;

   // The outage count starts at the rise of loss and clears as soon as it falls.
   // It saturates, since every threshold lies far below its top.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         loss_sub <= '0;
         tmr.ms_count <= '0;
      end else if (!tmr.loss) begin
         loss_sub <= '0;                                 // see RQ19
         tmr.ms_count <= '0;
      end else if (loss_ms_done) begin
         loss_sub <= '0;
         tmr.ms_count <= cnt_sat ? tmr.ms_count : tmr.ms_count + 1'b1; // see RQ19
      end else begin
         loss_sub <= loss_sub + 1'b1;
      end
   end

   // Free prescaler for the event time-of-day clock.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         free_sub <= '0;
         tmr.ms_tick <= 1'b0;
      end else begin
         free_sub <= free_ms_done ? '0 : free_sub + 1'b1;
         tmr.ms_tick <= free_ms_done;
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   // The count is zero in the cycle after loss is low.
   AST_CNT_CLEAR: assert property (!tmr.loss |=> tmr.ms_count == '0) // see RQ19
      else $error("Outage count not cleared after loss fell.");
endmodule // pfrs_ms_timer

// ### hdl/pfrs_top.sv
// Power-failure response sequencer: APB registers, detection and reaction state machine.
//
// Behaviour
// RQ1: Two modes; standard after configuration reset.
// RQ2: Standard: outage up to 20 ms ignored.
// RQ3: Standard: longer outage may be detected.
// RQ4: Standard detect: suspend, hold outputs, log time.
// RQ5: Standard: program resumes when supply returns.
// RQ6: Standard low logic: halt, outputs off, relay.
// RQ7: Standard: logic back above limit, reset restart.
// RQ8: Immediate AC: outage up to 10 ms ignored.
// RQ9: Immediate AC: 10 to 25 ms uncertain.
// RQ10: Immediate AC: over 25 ms always detected.
// RQ11: Immediate DC: outage up to 2 ms ignored.
// RQ12: Immediate DC: 2 to 10 ms uncertain.
// RQ13: Immediate DC: over 10 ms always detected.
// RQ14: Immediate detect: outputs, suspend, relay, log.
// RQ15: Immediate: momentary failure ends in reset restart.
// RQ16: Immediate low logic: controller fully disabled.
// RQ17: Immediate: logic back, reset restart.
// RQ18: Software picks immediate mode only where permitted.
// RQ19: Outage measured by a millisecond counter.
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "pfrs_defines.svh"

module pfrs_top #(
   parameter int CYC_PER_MS = `PFRS_CYC_PER_MS
) (
   input wire logic CLK,
   input wire logic RST,
   // APB slave.
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Supply monitor pins.
   input wire logic SUPPLY_LOSS,
   input wire logic LOGIC_LOW,
   // Reaction outputs.
   output logic RUN_EN,
   output logic OUT_HOLD,
   output logic OUT_CLEAR,
   output logic FAIL_RELAY,
   output logic CTRL_DISABLE,
   output logic RESET_RESTART,
   output logic RESUME,
   output logic LOG_STROBE,
   output logic [31:0] LOG_TIME,
   output logic IRQ
);

   // -------------------------------------------------------------------------
   // Pin synchronisation and outage timer
   // -------------------------------------------------------------------------
   logic [1:0] pins_q;   // Synchronised {logic_low, loss}.
   wire logic_low = pins_q[1];
   wire loss = pins_q[0];

   pfrs_tmr_if tmr ();
   assign tmr.loss = loss;

   pfrs_sync #(.W(2)) u_sync (
      .CLK(CLK),
      .RST(RST),
      .D({LOGIC_LOW, SUPPLY_LOSS}),
      .Q(pins_q)
   );

   pfrs_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmr (
      .CLK(CLK),
      .RST(RST),
      .tmr(tmr)
   );

   // -------------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------------
   logic [`PFRS_CTRL_W-1:0] ctrl;       // Mode, supply variant, output-at-stop.
   logic [`PFRS_EV_W-1:0] irq_stat;     // Sticky event bits.
   logic [`PFRS_EV_W-1:0] irq_mask;     // Interrupt enables.
   logic [31:0] clock_ms;               // Time of day in ms for the event log.
   pfrs_pkg::pfrs_state_e state;
   pfrs_pkg::pfrs_state_e next_state;

   // Configuration is whatever software chose; it alone keeps immediate mode
   // to permitted supply and processor combinations.
   wire imm = ctrl[`PFRS_CTRL_IMM];     // see RQ18
   wire dc = ctrl[`PFRS_CTRL_DC];
   wire clr_at_stop = ctrl[`PFRS_CTRL_CLR];

   // -------------------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------------------
   wire setup = PSEL && !PENABLE;
   wire wr = PSEL && PENABLE && PWRITE;
   wire hit_ctrl = (PADDR == `PFRS_OFS_CTRL);
   wire hit_status = (PADDR == `PFRS_OFS_STATUS);
   wire hit_stat = (PADDR == `PFRS_OFS_IRQ_STAT);
   wire hit_mask = (PADDR == `PFRS_OFS_IRQ_MASK);
   wire hit_log = (PADDR == `PFRS_OFS_LOG_TIME);
   wire hit_clock = (PADDR == `PFRS_OFS_CLOCK);
   wire mapped = hit_ctrl | hit_status | hit_stat | hit_mask | hit_log | hit_clock;
   wire [`PFRS_EV_W-1:0] w1c = (wr && hit_stat) ? PWDATA[`PFRS_EV_W-1:0] : '0;

   // Read data selection for the access phase.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`PFRS_CTRL_W-1:0] = ctrl;
      end else if (hit_status) begin
         rd_mux[`PFRS_MS_W-1:0] = tmr.ms_count;
         rd_mux[8] = loss;
         rd_mux[9] = logic_low;
         rd_mux[15:12] = state;
      end else if (hit_stat) begin
         rd_mux[`PFRS_EV_W-1:0] = irq_stat;
      end else if (hit_mask) begin
         rd_mux[`PFRS_EV_W-1:0] = irq_mask;
      end else if (hit_log) begin
         rd_mux = LOG_TIME;
      end else if (hit_clock) begin
         rd_mux = clock_ms;
      end
   end

   // Zero wait states: every access ends at its first access-phase edge.
   assign PREADY = 1'b1;

   // Read data and error are captured in the setup cycle so they come from flops.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PRDATA <= rd_mux;
         PSLVERR <= !mapped;
      end
   end

   // Writable registers; the mode comes up as standard after reset.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl <= `PFRS_CTRL_RST;            // see RQ1
         irq_mask <= `PFRS_EV_RST_VAL;
      end else if (wr) begin
         if (hit_ctrl) begin
            ctrl <= PWDATA[`PFRS_CTRL_W-1:0];
         end
         if (hit_mask) begin
            irq_mask <= PWDATA[`PFRS_EV_W-1:0];
         end
      end
   end

   // Time of day: software sets it, the free ms tick advances it.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         clock_ms <= 32'h0000_0000;
      end else if (wr && hit_clock) begin
         clock_ms <= PWDATA;
      end else if (tmr.ms_tick) begin
         clock_ms <= clock_ms + 32'h0000_0001;
      end
   end

   // -------------------------------------------------------------------------
   // Detection thresholds
   // -------------------------------------------------------------------------
   // Detection fires one ms past the ride-through limit of the mode, so every
   // outage up to the limit passes and each longer one is caught well inside
   // the sure-detection limit. Standard mode has no upper bound to meet.
   localparam logic [`PFRS_MS_W-1:0] STD_LIM = `PFRS_MS_W'(`PFRS_STD_IGNORE_MS);
   localparam logic [`PFRS_MS_W-1:0] AC_LIM = `PFRS_MS_W'(`PFRS_AC_IGNORE_MS);
   localparam logic [`PFRS_MS_W-1:0] DC_LIM = `PFRS_MS_W'(`PFRS_DC_IGNORE_MS);
   wire [`PFRS_MS_W-1:0] imm_lim = dc ? DC_LIM : AC_LIM;     // see RQ8, RQ11
   wire [`PFRS_MS_W-1:0] lim = imm ? imm_lim : STD_LIM;      // see RQ2, RQ3
   wire momentary = tmr.ms_count > lim;                       // see RQ9, RQ12

   // -------------------------------------------------------------------------
   // Reaction state machine
   // -------------------------------------------------------------------------
   // Low logic supply outranks a momentary outage in ST_RUN and the return of supply in ST_SUSP and ST_IMM_FAIL.
   always_comb begin
      next_state = state;
      unique case (state)
         pfrs_pkg::ST_RUN: begin
            if (logic_low) begin
               next_state = imm ? pfrs_pkg::ST_DIS : pfrs_pkg::ST_HALT; // see RQ6, RQ16
            end else if (momentary) begin
               next_state = imm ? pfrs_pkg::ST_IMM_OUT : pfrs_pkg::ST_SUSP; // see RQ4, RQ14
            end
         end
         pfrs_pkg::ST_SUSP: begin
            if (logic_low) begin
               next_state = pfrs_pkg::ST_HALT;
            end else if (!loss) begin
               next_state = pfrs_pkg::ST_RESUME;                 // see RQ5
            end
         end
         pfrs_pkg::ST_RESUME: next_state = pfrs_pkg::ST_RUN;
         pfrs_pkg::ST_IMM_OUT: next_state = pfrs_pkg::ST_IMM_SUSP; // see RQ14
         pfrs_pkg::ST_IMM_SUSP: next_state = pfrs_pkg::ST_IMM_FAIL;
         pfrs_pkg::ST_IMM_FAIL: begin
            if (logic_low) begin
               next_state = pfrs_pkg::ST_DIS;
            end else if (!loss) begin
               next_state = pfrs_pkg::ST_RESTART;                // see RQ15
            end
         end
         pfrs_pkg::ST_HALT: next_state = pfrs_pkg::ST_OFF;       // see RQ6
         pfrs_pkg::ST_OFF: next_state = pfrs_pkg::ST_FAIL;
         pfrs_pkg::ST_FAIL: begin
            if (!logic_low) begin
               next_state = pfrs_pkg::ST_RESTART;                // see RQ7
            end
         end
         pfrs_pkg::ST_DIS: begin
            if (!logic_low) begin
               next_state = pfrs_pkg::ST_RESTART;                // see RQ17
            end
         end
         pfrs_pkg::ST_RESTART: next_state = pfrs_pkg::ST_RUN;
         default: next_state = pfrs_pkg::ST_RUN;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state <= pfrs_pkg::ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   // -------------------------------------------------------------------------
   // Output decode
   // -------------------------------------------------------------------------
   wire in_imm = (state == pfrs_pkg::ST_IMM_OUT) || (state == pfrs_pkg::ST_IMM_SUSP) ||
                 (state == pfrs_pkg::ST_IMM_FAIL);
   wire d_run = (state == pfrs_pkg::ST_RUN);
   wire d_exec = d_run || (state == pfrs_pkg::ST_IMM_OUT);     // see RQ14
   wire d_hold = (state == pfrs_pkg::ST_SUSP) || (in_imm && !clr_at_stop); // see RQ4, RQ14
   wire d_clear = (in_imm && clr_at_stop) || (state == pfrs_pkg::ST_OFF) ||
                  (state == pfrs_pkg::ST_FAIL) || (state == pfrs_pkg::ST_DIS); // see RQ6
   wire d_relay = (state == pfrs_pkg::ST_IMM_FAIL) || (state == pfrs_pkg::ST_FAIL) ||
                  (state == pfrs_pkg::ST_DIS);
   wire d_dis = (state == pfrs_pkg::ST_DIS);                     // see RQ16
   wire enter_mom = d_run && !logic_low && momentary;
   wire enter_pwr = d_run && logic_low;

   // Outputs follow the state one cycle later, from flops, so no decode glitch
   // can reach the output modules or the relay driver.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RUN_EN <= 1'b0;
         OUT_HOLD <= 1'b0;
         OUT_CLEAR <= 1'b0;
         FAIL_RELAY <= 1'b0;
         CTRL_DISABLE <= 1'b0;
         RESET_RESTART <= 1'b0;
         RESUME <= 1'b0;
         LOG_STROBE <= 1'b0;
      end else begin
         RUN_EN <= d_exec;
         OUT_HOLD <= d_hold;
         OUT_CLEAR <= d_clear;
         FAIL_RELAY <= d_relay;
         CTRL_DISABLE <= d_dis;
         RESET_RESTART <= (state == pfrs_pkg::ST_RESTART);
         RESUME <= (state == pfrs_pkg::ST_RESUME);
         LOG_STROBE <= enter_mom;                                // see RQ4, RQ14
      end
   end

   // The event time is taken as the outage is recognised.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LOG_TIME <= 32'h0000_0000;
      end else if (enter_mom) begin
         LOG_TIME <= clock_ms;
      end
   end

   // -------------------------------------------------------------------------
   // Interrupts
   // -------------------------------------------------------------------------
   logic [`PFRS_EV_W-1:0] ev;
   always_comb begin
      ev = '0;
      ev[`PFRS_EV_MOM] = enter_mom;
      ev[`PFRS_EV_PWR] = enter_pwr;
      ev[`PFRS_EV_RST] = (state == pfrs_pkg::ST_RESTART);
      ev[`PFRS_EV_RES] = (state == pfrs_pkg::ST_RESUME);
   end

   // A new event in the same cycle as its write-one clear still sets the bit.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_stat <= `PFRS_EV_RST_VAL;
         IRQ <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~w1c) | ev;
         IRQ <= |(irq_stat & irq_mask);
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_pwr_steps;
      state == pfrs_pkg::ST_HALT ##1 state == pfrs_pkg::ST_OFF ##1 state == pfrs_pkg::ST_FAIL;
   endsequence
   sequence s_imm_steps;
      state == pfrs_pkg::ST_IMM_OUT ##1 (state == pfrs_pkg::ST_IMM_SUSP && RUN_EN)
         ##1 (state == pfrs_pkg::ST_IMM_FAIL && !RUN_EN && !FAIL_RELAY);
   endsequence

   AST_STD_IGNORE: assert property ( // see RQ2
      (d_run && !imm && !logic_low && tmr.ms_count <= STD_LIM) |=> d_run)
      else $error("Standard mode reacted to a short outage.");
   AST_AC_IGNORE: assert property ( // see RQ8
      (d_run && imm && !dc && !logic_low && tmr.ms_count <= AC_LIM) |=> d_run)
      else $error("Immediate AC mode reacted to a short outage.");
   AST_DC_IGNORE: assert property ( // see RQ11
      (d_run && imm && dc && !logic_low && tmr.ms_count <= DC_LIM) |=> d_run)
      else $error("Immediate DC mode reacted to a short outage.");
   AST_AC_ALWAYS: assert property ( // see RQ10
      !(d_run && imm && !dc && tmr.ms_count > `PFRS_MS_W'(`PFRS_AC_ALWAYS_MS)))
      else $error("Immediate AC outage past the sure limit not detected.");
   AST_DC_ALWAYS: assert property ( // see RQ13
      !(d_run && imm && dc && tmr.ms_count > `PFRS_MS_W'(`PFRS_DC_ALWAYS_MS)))
      else $error("Immediate DC outage past the sure limit not detected.");
   AST_STD_SUSPEND: assert property ( // see RQ4
      (enter_mom && !imm) |=> LOG_STROBE ##1 (!RUN_EN && OUT_HOLD && !FAIL_RELAY))
      else $error("Standard momentary failure not suspended with held outputs.");
   AST_STD_RESUME: assert property ( // see RQ5
      (state == pfrs_pkg::ST_SUSP && !loss && !logic_low) |=> ##1 (RESUME && !RESET_RESTART))
      else $error("Standard mode did not resume after the outage.");
   AST_PWR_ORDER: assert property ( // see RQ6
      (enter_pwr && !imm) |=> s_pwr_steps)
      else $error("Standard power failure steps out of order.");
   AST_STD_RESTART: assert property ( // see RQ7
      (state == pfrs_pkg::ST_FAIL && !logic_low) |=> ##1 RESET_RESTART ##1 RUN_EN)
      else $error("Standard recovery did not reset restart.");
   AST_IMM_ORDER: assert property ( // see RQ14
      (enter_mom && imm) |=> s_imm_steps ##1 FAIL_RELAY)
      else $error("Immediate momentary failure steps out of order.");
   AST_IMM_RESTART: assert property ( // see RQ15
      (state == pfrs_pkg::ST_IMM_FAIL && !loss && !logic_low) |=> ##1 (RESET_RESTART && !RESUME))
      else $error("Immediate momentary failure did not end in reset restart.");
   AST_IMM_DISABLE: assert property ( // see RQ16
      (enter_pwr && imm) |=> ##1 (CTRL_DISABLE && !RUN_EN && OUT_CLEAR))
      else $error("Immediate low logic supply did not disable the controller.");
   AST_IMM_RECOVER: assert property ( // see RQ17
      (state == pfrs_pkg::ST_DIS && !logic_low) |=> ##1 RESET_RESTART)
      else $error("Immediate recovery did not reset restart.");
endmodule // pfrs_top

// ### tb/pfrs_exec_model.sv
// Model of the program executor and fail relay that watch the sequencer outputs.
`timescale 1ns/1ps

module pfrs_exec_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic run_en,
   input wire logic resume,
   input wire logic reset_restart,
   input wire logic log_strobe,
   input wire logic fail_relay,
   output int log_cnt,
   output int res_cnt,
   output int rst_cnt,
   output int order_err
);
   // --------------------------------------------------------------------------
   // Event counters
   // --------------------------------------------------------------------------
   // Each one-cycle pulse is one event; counting them also catches a pulse that
   // stretches, because the bench compares exact deltas.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         log_cnt <= 0;
         res_cnt <= 0;
         rst_cnt <= 0;
         order_err <= 0;
      end else begin
         log_cnt <= log_cnt + int'(log_strobe);
         res_cnt <= res_cnt + int'(resume);
         rst_cnt <= rst_cnt + int'(reset_restart);
         // A relay energised while the program still runs means a wrong order.
         if (fail_relay && run_en) begin
            order_err <= order_err + 1;
         end
      end
   end
endmodule // pfrs_exec_model

// ### tb/tb_pfrs_top.sv
// Self-checking bench for the power-failure response sequencer.
`timescale 1ns/1ps
`include "pfrs_defines.svh"

module tb_pfrs_top;
   localparam int CPM = 10; // Short millisecond keeps the run brief.
   logic clk, rst, psel, penable, pwrite, loss, low, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, log_time, rd, tms;
   logic pready, pslverr, run_en, out_hold, out_clear, fail_relay;
   logic ctrl_dis, rstr, resume, log_stb, irq;
   int fail_count, n_checks, ev_log, ev_res, ev_rst, ord, b_log, b_res, b_rst, cyc;
   logic [2:0] cfg [5] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h7};
   int lim [5] = '{`PFRS_STD_IGNORE_MS, `PFRS_AC_IGNORE_MS, `PFRS_AC_IGNORE_MS,
                   `PFRS_DC_IGNORE_MS, `PFRS_DC_IGNORE_MS};
   int alw [5] = '{`PFRS_STD_IGNORE_MS + 3, `PFRS_AC_ALWAYS_MS + 1, `PFRS_AC_ALWAYS_MS + 1,
                   `PFRS_DC_ALWAYS_MS + 1, `PFRS_DC_ALWAYS_MS + 1};

   pfrs_top #(.CYC_PER_MS(CPM)) dut_u (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .SUPPLY_LOSS(loss), .LOGIC_LOW(low), .RUN_EN(run_en),
      .OUT_HOLD(out_hold), .OUT_CLEAR(out_clear), .FAIL_RELAY(fail_relay),
      .CTRL_DISABLE(ctrl_dis), .RESET_RESTART(rstr), .RESUME(resume), .LOG_STROBE(log_stb),
      .LOG_TIME(log_time), .IRQ(irq));
   pfrs_exec_model part_u (.clk(clk), .rst(rst), .run_en(run_en), .resume(resume),
      .reset_restart(rstr), .log_strobe(log_stb), .fail_relay(fail_relay), .log_cnt(ev_log),
      .res_cnt(ev_res), .rst_cnt(ev_rst), .order_err(ord));

   // --------------------------------------------------------------------------
   // Tasks and expectations
   // --------------------------------------------------------------------------
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high at an edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         end_sim();
      end
   endtask

   // Expected {run, hold, clear, relay} while a recognised outage lasts.
   function automatic logic [3:0] exp_out(input logic [2:0] c);
      if (!c[`PFRS_CTRL_IMM]) begin
         return 4'b0100;
      end
      return {1'b0, !c[`PFRS_CTRL_CLR], c[`PFRS_CTRL_CLR], 1'b1};
   endfunction

   // Hold the supply-loss pin for a number of cycles, then let the design settle.
   task automatic outage(input int n, input logic [3:0] exp);
      loss <= 1'b1;
      repeat (n) @(posedge clk);
      chk("outage outputs", exp, {run_en, out_hold, out_clear, fail_relay});
      loss <= 1'b0;
      repeat (40) @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // --------------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------------
   initial begin
      {rst, psel, penable, pwrite, loss, low} = 6'b100000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      fail_count = 0;
      n_checks = 0;
      void'($urandom(32'h779c_35f9));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("run after reset", 1, run_en);
      apb(1'b0, `PFRS_OFS_CTRL, 0, rd, er);
      chk("ctrl reset", 0, rd);
      apb(1'b0, 8'h40, 0, rd, er);
      chk("unmapped error", 1, er);
      // Every mode: ride-through at the limit, then a sure detection.
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `PFRS_OFS_CTRL, {29'h0, cfg[i]}, rd, er);
         {b_log, b_res, b_rst} = {ev_log, ev_res, ev_rst};
         outage(lim[i] * CPM, 4'b1000);
         chk("ride log", b_log, ev_log);
         cyc = (alw[i] + int'($urandom % 3)) * CPM;
         // Time of day set just before the outage, so the stamp is known to one ms.
         tms = $urandom & 32'h7FFF_FFFF;
         apb(1'b1, `PFRS_OFS_CLOCK, tms, rd, er);
         outage(cyc, exp_out(cfg[i]));
         chk("log count", b_log + 1, ev_log);
         chk("log time", 1, (log_time - tms - lim[i] - 1) <= 1);
         chk("resume count", b_res + int'(!cfg[i][0]), ev_res);
         chk("restart count", b_rst + int'(cfg[i][0]), ev_rst);
         chk("run back", 1, run_en);
         chk("irq masked", i > 0, irq);
         apb(1'b1, `PFRS_OFS_IRQ_MASK, 32'h0000_0001, rd, er);
         repeat (2) @(posedge clk);
         chk("irq set", 1, irq);
         apb(1'b1, `PFRS_OFS_IRQ_STAT, 32'h0000_000F, rd, er);
         repeat (2) @(posedge clk);
         chk("irq clear", 0, irq);
         $display("test %0d done", i);
      end
      // Logic supply low in standard and immediate mode, then recovery.
      for (int j = 0; j < 2; j++) begin
         apb(1'b1, `PFRS_OFS_CTRL, j, rd, er);
         b_rst = ev_rst;
         low <= 1'b1;
         repeat (60) @(posedge clk);
         chk("low outputs", 4'b0011, {run_en, out_hold, out_clear, fail_relay});
         chk("disable", j, ctrl_dis);
         low <= 1'b0;
         repeat (40) @(posedge clk);
         chk("low restart", b_rst + 1, ev_rst);
         chk("low run back", 1, run_en);
         $display("test low %0d done", j);
      end
      chk("relay order", 0, ord);
      end_sim();
   end
endmodule // tb_pfrs_top
